// ==== rtl/orx_pkg.sv ====
/*
 * orx_pkg: shared constants and types for the OR / return / rotate
 * execution slice of an 8-bit core.
 * Assumes a decoder upstream that maps instructions onto orx_op_t.
 */
package orx_pkg;

    // data path width and field positions
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned ROT_MSB  = 7;   // bit carried round to bit 0
    localparam int unsigned ROT_LSB  = 0;

    // reset values, plus the enable set by interrupt exit
    localparam logic [7:0]  ACC_RST  = 8'h00;
    localparam logic        ZERO_RST = 1'b0;
    localparam logic        GIE_RST  = 1'b0;
    localparam logic        GIE_SET  = 1'b1;

    // default address widths (data memory, program counter)
    localparam int unsigned MEM_AW   = 8;
    localparam int unsigned PC_AW    = 13;

    // instruction cycles per class
    localparam int unsigned CYC_SINGLE = 1;
    localparam int unsigned CYC_RETURN = 2;

    // operations handled by this slice
    typedef enum logic [2:0] {
        OP_NOP,
        OP_OR_MEM,
        OP_OR_IMM,
        OP_MEMORY_OR_STORE,
        OP_SUBROUTINE_EXIT,
        OP_EXIT_LOAD_IMM,
        OP_INTERRUPT_EXIT,
        OP_ROTATE_LEFT_MEMORY
    } orx_op_t;

    // execution sequencer
    typedef enum logic {
        ST_IDLE,
        ST_DUMMY
    } orx_state_t;

endpackage

// ==== rtl/orx_exec.sv ====
/*
 * orx_exec: execution unit for no-operation, the three OR forms, the
 * three return forms and rotate-left of a memory byte.
 * Assumes a decoder, data memory, hardware stack and interrupt
 * controller on the same clock; all inputs arrive synchronous.
 */
`timescale 1ns/1ns

module orx_exec #(
    parameter int unsigned DW = orx_pkg::DATA_W,
    parameter int unsigned AW = orx_pkg::MEM_AW,
    parameter int unsigned PW = orx_pkg::PC_AW
) (
    // clock, reset, enable
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    // instruction issue
    input  wire logic              issue,
    input  orx_pkg::orx_op_t       op,
    input  wire logic [DW-1:0]     imm,
    input  wire logic [AW-1:0]     mem_addr,
    input  wire logic [DW-1:0]     mem_rdata,
    // stack and interrupt controller
    input  wire logic [PW-1:0]     stack_top,
    input  wire logic              irq_pending,
    // architectural state
    output logic [DW-1:0]          acc_q,
    output logic                   zero_q,
    output logic                   global_irq_enable_q,
    // data memory write port
    output logic                   mem_we_q,
    output logic [AW-1:0]          mem_waddr_q,
    output logic [DW-1:0]          mem_wdata_q,
    // program flow
    output logic                   stack_pop_q,
    output logic                   pc_load_q,
    output logic [PW-1:0]          pc_target_q,
    output logic                   irq_take_q,
    output logic                   busy_q,
    output logic                   done_q
);

    ////////////////////////////////////////////////////////////////////
    // state record
    // one packed record keeps reset and enable handling in one place

    typedef struct packed {
        orx_pkg::orx_state_t st;
        logic [DW-1:0]       acc;
        logic                zero;
        logic                gie;
        logic                mem_we;
        logic [AW-1:0]       waddr;
        logic [DW-1:0]       wdata;
        logic                pop;
        logic                pc_load;
        logic [PW-1:0]       pc_target;
        logic                irq_take;
        logic                busy;
        logic                done;
    } orx_regs_t;

    orx_regs_t r_q;
    orx_regs_t r_d;

    logic [DW-1:0] or_mem;
    logic [DW-1:0] or_imm;
    logic [DW-1:0] rot_l;
    logic          accept;

    ////////////////////////////////////////////////////////////////////
    // operand paths

    // results are formed every cycle; only the decoded op commits one
    // the rotate is only a rewire of the read byte, no gates
    assign or_mem = r_q.acc | mem_rdata;
    assign or_imm = r_q.acc | imm;
    assign rot_l  = {mem_rdata[orx_pkg::ROT_MSB-1:orx_pkg::ROT_LSB],
                     mem_rdata[orx_pkg::ROT_MSB]};
    // no new issue during the dummy cycle of a return
    // a refused issue leaves no trace; the decoder must hold it
    assign accept = issue && (r_q.st == orx_pkg::ST_IDLE);

    ////////////////////////////////////////////////////////////////////
    // next state

    // pulse outputs default low so each strobe lasts one cycle
    always_comb begin
        r_d          = r_q;
        r_d.mem_we   = 1'b0;
        r_d.pop      = 1'b0;
        r_d.pc_load  = 1'b0;
        r_d.irq_take = 1'b0;
        r_d.done     = 1'b0;
        case (r_q.st)
            orx_pkg::ST_IDLE: begin
                if (accept) begin
                    case (op)
                        orx_pkg::OP_NOP: begin
                            // nothing moves but the completion strobe
                            r_d.done = 1'b1;
                        end
                        orx_pkg::OP_OR_MEM: begin
                            r_d.acc  = or_mem;
                            r_d.zero = (or_mem == '0);
                            r_d.done = 1'b1;
                        end
                        orx_pkg::OP_OR_IMM: begin
                            r_d.acc  = or_imm;
                            r_d.zero = (or_imm == '0);
                            r_d.done = 1'b1;
                        end
                        orx_pkg::OP_MEMORY_OR_STORE: begin
                            // accumulator left alone; flag and write only
                            r_d.mem_we = 1'b1;
                            r_d.waddr  = mem_addr;
                            r_d.wdata  = or_mem;
                            r_d.zero   = (or_mem == '0);
                            r_d.done   = 1'b1;
                        end
                        orx_pkg::OP_SUBROUTINE_EXIT: begin
                            r_d.pop       = 1'b1;
                            r_d.pc_load   = 1'b1;
                            r_d.pc_target = stack_top;
                            r_d.busy      = 1'b1;
                            r_d.st        = orx_pkg::ST_DUMMY;
                        end
                        orx_pkg::OP_EXIT_LOAD_IMM: begin
                            r_d.pop       = 1'b1;
                            r_d.pc_load   = 1'b1;
                            r_d.pc_target = stack_top;
                            r_d.acc       = imm;
                            r_d.busy      = 1'b1;
                            r_d.st        = orx_pkg::ST_DUMMY;
                        end
                        orx_pkg::OP_INTERRUPT_EXIT: begin
                            r_d.pop       = 1'b1;
                            r_d.pc_load   = 1'b1;
                            r_d.pc_target = stack_top;
                            r_d.gie       = orx_pkg::GIE_SET;
                            r_d.busy      = 1'b1;
                            r_d.st        = orx_pkg::ST_DUMMY;
                        end
                        orx_pkg::OP_ROTATE_LEFT_MEMORY: begin
                            r_d.mem_we = 1'b1;
                            r_d.waddr  = mem_addr;
                            r_d.wdata  = rot_l;
                            // zero untouched: a rotate moves no flag
                            r_d.done   = 1'b1;
                        end
                        // codes outside the list behave as no-operation
                        default: begin
                            r_d.done = 1'b1;
                        end
                    endcase
                end
            end
            orx_pkg::ST_DUMMY: begin
                // dummy cycle: restored address settles in the pc
                r_d.busy = 1'b0;
                r_d.done = 1'b1;
                r_d.st   = orx_pkg::ST_IDLE;
                // a waiting request vectors before main code resumes;
                // entry drops the enable, as interrupt entry always does
                // registered gie: the enable set by this very exit counts
                if (irq_pending && r_q.gie) begin
                    r_d.irq_take = 1'b1;
                    r_d.gie      = orx_pkg::GIE_RST;
                end
            end
            // unreachable with two states; falls back to idle anyway
            default: begin
                r_d.st   = orx_pkg::ST_IDLE;
                r_d.busy = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // state register

    // clk_en low freezes everything, strobes included
    // a stalled strobe stays high, so the far side must qualify it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // constants only; the record clear takes the strobes low
            r_q           <= '0;
            r_q.st        <= orx_pkg::ST_IDLE;
            r_q.acc       <= orx_pkg::ACC_RST;
            r_q.zero      <= orx_pkg::ZERO_RST;
            r_q.gie       <= orx_pkg::GIE_RST;
        end else if (clk_en) begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, straight from the record
    // every output is a record field, so none has a combinational path

    assign acc_q               = r_q.acc;
    assign zero_q              = r_q.zero;
    assign global_irq_enable_q = r_q.gie;
    assign mem_we_q            = r_q.mem_we;
    assign mem_waddr_q         = r_q.waddr;
    assign mem_wdata_q         = r_q.wdata;
    assign stack_pop_q         = r_q.pop;
    assign pc_load_q           = r_q.pc_load;
    assign pc_target_q         = r_q.pc_target;
    assign irq_take_q          = r_q.irq_take;
    assign busy_q              = r_q.busy;
    assign done_q              = r_q.done;

endmodule

// ==== tb/orx_exec_monitor.sv ====
/* orx_exec_monitor: port checks for orx_exec.
   Assumes a bind onto orx_exec, one clock, reset low. */
`timescale 1ns/1ns
module orx_exec_monitor #(
    parameter int unsigned DW = 8,
    parameter int unsigned PW = 13
) (
    // clock, reset, issue side, data and pc results (grouped to keep the file short)
    input wire logic          sys_clk, rst_n, clk_en, issue, irq_pending,
    input orx_pkg::orx_op_t   op,
    input wire logic [DW-1:0] imm, mem_rdata, acc_q, mem_wdata_q,
    input wire logic [PW-1:0] stack_top, pc_target_q,
    // flags and strobes
    input wire logic          zero_q, global_irq_enable_q, mem_we_q,
    input wire logic          stack_pop_q, pc_load_q, irq_take_q,
    input wire logic          busy_q, done_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // issue only counts outside the dummy cycle
    wire logic take = clk_en && issue && !busy_q;
    wire logic ret  = op inside {orx_pkg::OP_SUBROUTINE_EXIT,
        orx_pkg::OP_EXIT_LOAD_IMM, orx_pkg::OP_INTERRUPT_EXIT};
    // return steps: pop cycle, then completion
    sequence s_pop;
        pc_load_q && stack_pop_q && busy_q && pc_target_q == $past(stack_top);
    endsequence
    sequence s_finish;
        done_q && !busy_q && !pc_load_q;
    endsequence
    a_return_steps: assert property (
        take && ret |=> s_pop ##1 s_finish) else $error("return steps");
    a_or_mem_acc: assert property (
        take && op == orx_pkg::OP_OR_MEM |=> done_q && !busy_q &&
        acc_q == ($past(acc_q) | $past(mem_rdata)) && zero_q == (acc_q == '0))
        else $error("or memory");
    a_or_imm_acc: assert property (
        take && op == orx_pkg::OP_OR_IMM |=> done_q &&
        acc_q == ($past(acc_q) | $past(imm)) && zero_q == (acc_q == '0))
        else $error("or immediate");
    a_or_store_mem: assert property (
        take && op == orx_pkg::OP_MEMORY_OR_STORE |=> mem_we_q &&
        mem_wdata_q == ($past(acc_q) | $past(mem_rdata)) && $stable(acc_q))
        else $error("or store");
    a_rotate_mem: assert property (
        take && op == orx_pkg::OP_ROTATE_LEFT_MEMORY |=> mem_we_q &&
        mem_wdata_q == (($past(mem_rdata) << 1) | ($past(mem_rdata) >> (DW-1)))
        && $stable(zero_q)) else $error("rotate");
    a_nop_quiet: assert property (
        take && op == orx_pkg::OP_NOP |=> done_q && !mem_we_q && !pc_load_q
        && $stable(acc_q) && $stable(zero_q)) else $error("nop changed state");
    a_exit_imm_acc: assert property (
        take && op == orx_pkg::OP_EXIT_LOAD_IMM |=> acc_q == $past(imm)
        && $stable(zero_q)) else $error("exit immediate");
    a_int_exit_gie: assert property (
        take && op == orx_pkg::OP_INTERRUPT_EXIT |=> global_irq_enable_q
        && $stable(zero_q)) else $error("interrupt exit");
    a_irq_service: assert property (
        busy_q && clk_en && irq_pending && global_irq_enable_q |=>
        irq_take_q && done_q) else $error("pending irq not taken");
endmodule

// ==== tb/or_return_rotate_exec_tb.sv ====
/* or_return_rotate_exec_tb: directed scenarios for orx_exec.
   Assumes orx_pkg, orx_exec and the monitor compiled first. */
`timescale 1ns/1ns
module or_return_rotate_exec_tb;
    logic             sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
    logic             issue = 1'b0, irq_pending = 1'b0;
    orx_pkg::orx_op_t op = orx_pkg::OP_NOP;
    logic [7:0]       imm = 8'h00, mem_addr = 8'h00, mem_rdata = 8'h00;
    logic [12:0]      stack_top = 13'h0000, pc_target_q;
    logic [7:0]       acc_q, mem_waddr_q, mem_wdata_q;
    logic             zero_q, global_irq_enable_q, mem_we_q, stack_pop_q;
    logic             pc_load_q, irq_take_q, busy_q, done_q;
    int               num_errors = 0, n_tests = 0;
    orx_exec i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .issue(issue), .op(op), .imm(imm), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .stack_top(stack_top),
        .irq_pending(irq_pending), .acc_q(acc_q), .zero_q(zero_q),
        .global_irq_enable_q(global_irq_enable_q), .mem_we_q(mem_we_q),
        .mem_waddr_q(mem_waddr_q), .mem_wdata_q(mem_wdata_q),
        .stack_pop_q(stack_pop_q), .pc_load_q(pc_load_q),
        .pc_target_q(pc_target_q), .irq_take_q(irq_take_q),
        .busy_q(busy_q), .done_q(done_q));
    initial forever #50 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(string name, logic [12:0] exp, logic [12:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one issue; returns just after the taking edge has landed
    task automatic run(orx_pkg::orx_op_t o, logic [7:0] x, logic [7:0] rd,
                       logic [12:0] t);
        @(posedge sys_clk);
        issue     <= 1'b1;
        op        <= o;
        imm       <= x;
        mem_rdata <= rd;
        mem_addr  <= t[7:0];
        stack_top <= t;
        @(posedge sys_clk);
        issue     <= 1'b0;
        #1;
    endtask
    task automatic t_or_forms;
        run(orx_pkg::OP_OR_IMM, 8'h00, 8'hFF, 13'h0000);
        check("zero_q", 1'b1, zero_q);
        run(orx_pkg::OP_OR_IMM, 8'h5A, 8'hFF, 13'h0000);
        check("acc_q", 8'h5A, acc_q);
        run(orx_pkg::OP_OR_MEM, 8'hFF, 8'h81, 13'h0000);
        check("acc_q", 8'hDB, acc_q);
        check("done_q", 1'b1, done_q);
    endtask
    task automatic t_store_rotate;
        run(orx_pkg::OP_MEMORY_OR_STORE, 8'h00, 8'h24, 13'h003C);
        check("mem_wdata_q", 8'hFF, mem_wdata_q);
        check("mem_waddr_q", 8'h3C, mem_waddr_q);
        check("acc_q", 8'hDB, acc_q);
        run(orx_pkg::OP_ROTATE_LEFT_MEMORY, 8'h00, 8'h81, 13'h0011);
        check("mem_wdata_q", 8'h03, mem_wdata_q);
        run(orx_pkg::OP_NOP, 8'hFF, 8'hFF, 13'h0000);
        check("mem_we_q", 1'b0, mem_we_q);
        check("acc_q", 8'hDB, acc_q);
    endtask
    // clk_en low: an issue must leave the accumulator alone
    task automatic t_freeze;
        @(posedge sys_clk);
        clk_en <= 1'b0;
        run(orx_pkg::OP_OR_IMM, 8'h24, 8'h00, 13'h0000);
        check("acc_q", 8'hDB, acc_q);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        check("acc_q", 8'hDB, acc_q);
    endtask
    task automatic t_returns;
        run(orx_pkg::OP_SUBROUTINE_EXIT, 8'h00, 8'h00, 13'h1ABC);
        check("pc_target_q", 13'h1ABC, pc_target_q);
        check("pc_load_q", 1'b1, pc_load_q);
        check("stack_pop_q", 1'b1, stack_pop_q);
        check("busy_q", 1'b1, busy_q);
        @(posedge sys_clk);
        #1;
        check("done_q", 1'b1, done_q);
        check("busy_q", 1'b0, busy_q);
        run(orx_pkg::OP_EXIT_LOAD_IMM, 8'h00, 8'h00, 13'h0001);
        check("zero_q", 1'b0, zero_q);
        check("acc_q", 8'h00, acc_q);
        @(posedge sys_clk);
        irq_pending <= 1'b1;
        run(orx_pkg::OP_INTERRUPT_EXIT, 8'h00, 8'h00, 13'h0800);
        check("gie", 1'b1, global_irq_enable_q);
        @(posedge sys_clk);
        #1;
        check("irq_take_q", 1'b1, irq_take_q);
        check("done_q", 1'b1, done_q);
    endtask
    task automatic final_report;
        if (num_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_or_forms();
        t_store_rotate();
        t_freeze();
        t_returns();
        final_report();
    end
    // the sequence needs 33 cycles; 500 means a hang
    initial begin
        repeat (500) @(posedge sys_clk);
        num_errors++;
        final_report();
    end
endmodule
bind orx_exec orx_exec_monitor #(.DW(DW), .PW(PW)) i_mon (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .issue(issue),
    .irq_pending(irq_pending), .op(op), .imm(imm), .mem_rdata(mem_rdata),
    .acc_q(acc_q), .mem_wdata_q(mem_wdata_q), .stack_top(stack_top),
    .pc_target_q(pc_target_q), .zero_q(zero_q), .mem_we_q(mem_we_q),
    .global_irq_enable_q(global_irq_enable_q), .stack_pop_q(stack_pop_q),
    .pc_load_q(pc_load_q), .irq_take_q(irq_take_q), .busy_q(busy_q),
    .done_q(done_q));
